// ==== src/cpu_reset_strap_sequencer.sv ====
// Device side of reset release, strap capture and bus drive start
//
// Functional notes
// - Ratio is fixed at manufacture; straps never change it.
// - Device CMOS output pulses last at least two clocks.
// - Outputs valid no sooner than one clock after reset release.
// - Bus drive starts at least four clocks after reset release.
`timescale 1ns/100ps
module cpu_reset_strap_sequencer (
    input  wire logic               mclk_i,
    input  wire logic               arst_n_i,
    input  wire logic               cpu_reset_n_i,
    input  wire logic               power_ok_in_i,
    input  wire logic               term_supply_ok_i,
    input  wire rst_seq_pkg::straps_s straps_i,
    input  wire logic [1:0]         local_irq_lines_i,
    input  wire logic               err_event_i,
    output rst_seq_pkg::straps_s    straps_o,
    output rst_seq_pkg::ratio_e     ratio_o,
    output logic                    ratio_mismatch_o,
    output logic                    outputs_valid_o,
    output logic                    bus_drive_en_o,
    output logic [1:0]              lint_event_o,
    output logic                    err_pulse_o
);
    import rst_seq_pkg::*;

    // ------------------------------------------------------------
    // Reset input tracking
    // ------------------------------------------------------------
    seq_e       state_q;
    logic       rst_prev_q;
    logic [2:0] cnt_q;
    logic       release_w;
    logic       run_w;

    assign release_w = rst_prev_q == 1'b0 && cpu_reset_n_i;
    assign run_w     = power_ok_in_i && term_supply_ok_i;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_prev_q <= 1'b0;
        end else begin
            rst_prev_q <= cpu_reset_n_i;
        end
    end

    // ------------------------------------------------------------
    // Release sequence
    // ------------------------------------------------------------
    // Reset is sampled, so the release lands on a clock edge
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_RESET;
            cnt_q   <= CNT_ZERO;
        end else if (!cpu_reset_n_i || !run_w) begin
            state_q <= ST_RESET;
            cnt_q   <= CNT_ZERO;
        end else begin
            case (state_q)
                ST_RESET: begin
                    if (release_w) begin
                        state_q <= ST_WAIT_VALID;
                        cnt_q   <= CNT_ONE;
                    end
                end
                ST_WAIT_VALID: begin
                    cnt_q <= cnt_q + CNT_ONE;
                    if (cnt_q >= 3'(VALID_OUT_CYC)) begin
                        state_q <= ST_WAIT_DRIVE;
                    end
                end
                ST_WAIT_DRIVE: begin
                    cnt_q <= cnt_q + CNT_ONE;
                    if (cnt_q >= 3'(DRIVE_CYC - 1)) begin
                        state_q <= ST_RUN;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            outputs_valid_o <= 1'b0;
            bus_drive_en_o  <= 1'b0;
        end else begin
            outputs_valid_o <= state_q == ST_WAIT_DRIVE || state_q == ST_RUN;
            bus_drive_en_o  <= state_q == ST_RUN;
        end
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // Captured on the release edge, when the straps are held
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            straps_o <= '0;
        end else if (state_q == ST_RESET && release_w && run_w) begin
            straps_o <= straps_i;
        end
    end

    // Ratio comes from the fused code only; straps just get compared
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ratio_o          <= RATIO_7;
            ratio_mismatch_o <= 1'b0;
        end else begin
            case (FUSED_RATIO)
                RATIO6_CODE: ratio_o <= RATIO_6;
                RATIO7_CODE: ratio_o <= RATIO_7;
                RATIO8_CODE: ratio_o <= RATIO_8;
                default:     ratio_o <= RATIO_BAD;
            endcase
            ratio_mismatch_o <= outputs_valid_o && straps_o.ratio_strap != FUSED_RATIO;
        end
    end

    // ------------------------------------------------------------
    // Local interrupt edge detect
    // ------------------------------------------------------------
    // A line counts as an edge event in the first clock it reads high after reading low
    logic [1:0] lint_prev_q;
    logic [1:0] lint_ev_w;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lint_prev_q <= LINT_IDLE;
        end else begin
            lint_prev_q <= local_irq_lines_i;
        end
    end
    assign lint_ev_w = local_irq_lines_i & ~lint_prev_q;

    // Event outputs are stretched so slow observers never miss them
    for (genvar g = 0; g < 2; g++) begin : g_lint
        pulse_stretch u_lint (
            .mclk_i   (mclk_i),
            .arst_n_i (arst_n_i),
            .req_i    (lint_ev_w[g] && outputs_valid_o),
            .pulse_o  (lint_event_o[g])
        );
    end

    pulse_stretch u_err (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .req_i    (err_event_i && outputs_valid_o),
        .pulse_o  (err_pulse_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_release;
        $rose(cpu_reset_n_i) && run_w ##0 state_q == ST_RESET;
    endsequence

    // Four samples after release, so a drive one clock early is caught
    sequence s_quiet_four;
        !bus_drive_en_o [*4];
    endsequence

    a_drive_late: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_release |=> s_quiet_four)
        else $error("bus drive began under four clocks after release");

    a_valid_late: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_release |=> !outputs_valid_o [*2])
        else $error("outputs valid too soon after release");

    a_valid_comes: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_release ##1 (cpu_reset_n_i && run_w) [*2] |=> outputs_valid_o)
        else $error("outputs did not become valid after release");

    a_drive_comes: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_release ##1 (cpu_reset_n_i && run_w) [*5] |-> bus_drive_en_o)
        else $error("bus drive did not start after release");

    a_drive_order: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        bus_drive_en_o |-> outputs_valid_o)
        else $error("bus drive without valid outputs");

    a_strap_take: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        s_release |=> straps_o == $past(straps_i))
        else $error("straps not captured on the release edge");

    a_flag_gated: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ratio_mismatch_o |-> $past(outputs_valid_o))
        else $error("ratio flag raised before outputs were valid");

    a_ratio_fixed: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        ##1 $stable(ratio_o))
        else $error("clock ratio changed");

    a_straps_kept: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        outputs_valid_o && $past(outputs_valid_o) |-> $stable(straps_o))
        else $error("captured straps changed after release");

    a_valid_drop: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        !cpu_reset_n_i |=> ##1 !outputs_valid_o && !bus_drive_en_o)
        else $error("outputs stayed on under reset");

    a_err_stretch: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(err_pulse_o) |=> err_pulse_o)
        else $error("error pulse shorter than two clocks");

    a_lint_stretch: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(lint_event_o[0]) |=> lint_event_o[0])
        else $error("interrupt event pulse too short");
endmodule

// ==== src/pulse_stretch.sv ====
// Holds each output pulse for a least number of clocks
`timescale 1ns/100ps
module pulse_stretch (
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    input  wire logic req_i,
    output logic      pulse_o
);
    import rst_seq_pkg::*;

    logic [2:0] cnt_q;

    // Extends any request to at least the least pulse width
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_q   <= CNT_ZERO;
            pulse_o <= 1'b0;
        end else if (req_i) begin
            cnt_q   <= 3'(MIN_PULSE_CYC - 1);
            pulse_o <= 1'b1;
        end else if (cnt_q != CNT_ZERO) begin
            cnt_q   <= cnt_q - CNT_ONE;
            pulse_o <= 1'b1;
        end else begin
            pulse_o <= 1'b0;
        end
    end

    a_pulse_min: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        $rose(pulse_o) |=> pulse_o)
        else $error("output pulse shorter than two clocks");
endmodule

// ==== src/rst_seq_pkg.sv ====
// Constants and types for the processor reset and strap sequencer
package rst_seq_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    // Straps: bits 27,25:22 packed as {b27,b25..b22}
    localparam logic [4:0] RATIO6_CODE      = 5'h0b;
    localparam logic [4:0] RATIO7_CODE      = 5'h0c;
    localparam logic [4:0] RATIO8_CODE      = 5'h0d;
    localparam logic [4:0] FUSED_RATIO      = RATIO7_CODE;
    localparam int unsigned STRAP_SETUP_CYC = 4;
    localparam int unsigned STRAP_HOLD_CYC  = 2;
    localparam int unsigned STRAP_DROP_CYC  = 20;
    localparam int unsigned VALID_OUT_CYC   = 1;
    localparam int unsigned DRIVE_CYC       = 4;
    localparam int unsigned MIN_PULSE_CYC   = 2;
    localparam int unsigned LINT_PULSE_CYC  = 6;
    localparam logic [2:0] CNT_ONE          = 3'h1;
    localparam logic [2:0] CNT_ZERO         = 3'h0;
    localparam logic [4:0] SCNT_ZERO        = 5'h00;
    localparam logic [4:0] SCNT_ONE         = 5'h01;
    localparam logic [1:0] LINT_IDLE        = 2'h0;

    typedef enum logic [1:0] {
        RATIO_6,
        RATIO_7,
        RATIO_8,
        RATIO_BAD
    } ratio_e;

    typedef struct packed {
        logic [10:0] addr_strap;
        logic        bus_request0_strap;
        logic        flush_strap;
        logic        init_strap;
        logic        intc_serial_data0;
        logic [4:0]  ratio_strap;
    } straps_s;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_WAIT_VALID,
        ST_WAIT_DRIVE,
        ST_RUN
    } seq_e;
endpackage

// ==== test/cpu_reset_strap_sequencer_tb_top.sv ====
// Self-checking bench for the reset and strap sequencer
`timescale 1ns/100ps
module cpu_reset_strap_sequencer_tb_top;
    import rst_seq_pkg::*;
    logic       mclk_i;
    logic       arst_n_i;
    logic       rst_n;
    logic       pwr_ok;
    logic       term_ok;
    straps_s    straps;
    logic [1:0] irq;
    logic       err_ev;
    straps_s    st_o;
    ratio_e     ratio;
    logic       mism;
    logic       valid;
    logic       drive;
    logic [1:0] lint;
    logic       err_p;
    int         n_mismatch = 0;
    int         n_tests    = 0;
    logic [4:0] codes [4]  = '{RATIO6_CODE, RATIO7_CODE, RATIO8_CODE, 5'h1f};

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    sys_seq_model sys_seq_model_i (.mclk_i(mclk_i), .rst_n_o(rst_n), .pwr_ok_o(pwr_ok),
        .term_ok_o(term_ok), .straps_o(straps));

    cpu_reset_strap_sequencer cpu_reset_strap_sequencer_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .cpu_reset_n_i(rst_n), .power_ok_in_i(pwr_ok), .term_supply_ok_i(term_ok),
        .straps_i(straps), .local_irq_lines_i(irq), .err_event_i(err_ev), .straps_o(st_o),
        .ratio_o(ratio), .ratio_mismatch_o(mism), .outputs_valid_o(valid),
        .bus_drive_en_o(drive), .lint_event_o(lint), .err_pulse_o(err_p));

    // ------
    // Shared helpers
    // ------
    task automatic check(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------
    // Scenarios
    // ------
    task automatic one_run(input logic [4:0] code);
        straps_s s;
        int      k;
        s = '{11'h5a5, 1'b1, 1'b0, 1'b1, 1'b0, code};
        fork
            sys_seq_model_i.run(s);
            begin
                repeat (3) @(negedge mclk_i);
                check(valid === 1'b0 && drive === 1'b0, "no drop on reset");
                k = 0;
                do begin
                    @(posedge mclk_i);
                    k++;
                end while (rst_n !== 1'b1 && k < 400);
                if (k >= 400) begin
                    check(1'b0, "release timeout");
                    finish_test();
                end
                for (int c = 1; c <= 6; c++) begin
                    @(posedge mclk_i);
                    @(negedge mclk_i);
                    check(valid === (c >= 2), "valid timing");
                    check(drive === (c >= 4), "drive timing");
                    check(st_o === s, "captured straps");
                    check(ratio === RATIO_7, "ratio moved");
                    check(mism === (c >= 3 && code != FUSED_RATIO), "ratio flag");
                end
            end
        join
        $display("test run ratio %h done", code);
    endtask

    task automatic events(input logic on);
        @(negedge mclk_i);
        err_ev = 1'b1;
        irq    = 2'h3;
        @(negedge mclk_i);
        err_ev = 1'b0;
        // Pulse stands for the two clocks after the request edge
        repeat (2) begin
            check(err_p === on, "err pulse");
            check(lint === {on, on}, "lint pulse");
            @(negedge mclk_i);
        end
        // Held lines must not fire again, one request gives one pulse
        check(err_p === 1'b0, "err pulse too long");
        check(lint === LINT_IDLE, "lint pulse too long");
        repeat (4) @(negedge mclk_i); // Lines held seven clocks
        irq = LINT_IDLE;
        $display("test events %0d done", on);
    endtask

    initial begin
        arst_n_i = 1'b0;
        irq      = LINT_IDLE;
        err_ev   = 1'b0;
        repeat (12) @(negedge mclk_i);
        arst_n_i = 1'b1;
        check(valid === 1'b0 && drive === 1'b0 && ratio === RATIO_7, "reset values");
        $display("test reset done");
        events(1'b0);
        foreach (codes[i]) begin
            one_run(codes[i]);
            events(1'b1);
        end
        finish_test();
    end
endmodule

// ==== test/sys_seq_model.sv ====
// Behavioural system-side power, reset and strap sequencer
`timescale 1ns/100ps
module sys_seq_model
    import rst_seq_pkg::*;
#(
    parameter int unsigned HOLD_CYC = 50,
    parameter int unsigned OFF_CYC  = 100
) (
    input  wire logic mclk_i,
    output logic      rst_n_o,
    output logic      pwr_ok_o,
    output logic      term_ok_o,
    output straps_s   straps_o
);
    // ------
    // Power-up state
    // ------
    initial begin
        rst_n_o   = 1'b0;
        pwr_ok_o  = 1'b0;
        term_ok_o = 1'b0;
        straps_o  = '1;
    end
    // ------
    // Release sequence; HOLD_CYC shortens the 1 ms hold to keep runs short
    // ------
    task automatic run(input straps_s s);
        @(negedge mclk_i);
        rst_n_o   = 1'b0;
        pwr_ok_o  = 1'b0;
        term_ok_o = 1'b0;
        repeat (OFF_CYC) @(negedge mclk_i);
        term_ok_o = 1'b1;
        repeat (HOLD_CYC) @(negedge mclk_i);
        pwr_ok_o = 1'b1;
        straps_o = s;
        repeat (HOLD_CYC) @(negedge mclk_i);
        rst_n_o = 1'b1;
        repeat (STRAP_HOLD_CYC + 1) @(negedge mclk_i);
        straps_o = ~s; // Removed straps float away
    endtask
endmodule
